//--- shared/dmx_consts.svh
// dmx_consts.svh: register offsets, field positions, reset values, fixed sizes.
// included by bare name from the channel pair, the crc unit and the testbench.
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH
// register byte offsets
`define DMX_CTRL        8'h00
`define DMX_SRC         8'h04
`define DMX_DST         8'h08
`define DMX_CNT         8'h0c
`define DMX_STRIDE      8'h10
`define DMX_DPTR        8'h14
`define DMX_YCNT        8'h18
`define DMX_POLY        8'h1c
`define DMX_EXPECT      8'h20
`define DMX_FILL        8'h24
`define DMX_STAT        8'h28
`define DMX_CRC         8'h2c
// control word fields
`define DMX_F_START     0
`define DMX_F_MODE_LO   1
`define DMX_F_MODE_HI   3
`define DMX_F_OP_LO     4
`define DMX_F_OP_HI     6
`define DMX_F_BITREV    7
`define DMX_F_BYTEREV   8
`define DMX_F_WIDE      9
`define DMX_F_HALF      10
`define DMX_F_TRIGEN    11
// status fields
`define DMX_F_BUSY      0
`define DMX_F_ERR       1
// descriptor configuration word fields
`define DMX_F_CFG_STOP  0
`define DMX_F_CFG_STR   16
// reset values
`define DMX_RST_WORD    32'h0000_0000
`define DMX_RST_POLY    32'h04c1_1db7
`define DMX_CRC_SEED    32'hffff_ffff
// element and descriptor steps in bytes
`define DMX_NARROW_STEP 32'h0000_0004
`define DMX_WIDE_STEP   32'h0000_0008
`define DMX_DESC_STEP   32'h0000_0004
`endif

//--- shared/dmx_pkg.sv
// dmx_pkg: types of the memory-to-memory channel pair.
// assumes nothing beyond a SystemVerilog compiler.
package dmx_pkg;
  typedef enum logic [2:0] {
    M_STOP   = 3'b000,
    M_CIRC   = 3'b001,
    M_RING   = 3'b010,
    M_LIST1  = 3'b011,
    M_ARRAY2 = 3'b100,
    M_LIST2  = 3'b101
  } dmx_mode_t;
  typedef enum logic [2:0] {
    OP_COPY   = 3'b000,
    OP_SCAN   = 3'b001,
    OP_XFER   = 3'b010,
    OP_FILL   = 3'b011,
    OP_VERIFY = 3'b100
  } dmx_op_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_RD    = 3'b010,
    S_WR    = 3'b011,
    S_NEXT  = 3'b100
  } dmx_state_t;
  typedef enum logic [2:0] {
    FD_NEXT = 3'b000,
    FD_ADDR = 3'b001,
    FD_LEN  = 3'b010,
    FD_CFG  = 3'b011,
    FD_YCNT = 3'b100,
    FD_YSTR = 3'b101
  } dmx_field_t;
endpackage

//--- verilog/dmx_crc.sv
// dmx_crc: crc32 signature unit fed word by word by the channel pair.
// assumes feed, clr and chk are single-cycle pulses on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"
module dmx_crc (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clr,
  input  wire logic        feed,
  input  wire logic [31:0] din,
  input  wire logic [31:0] poly,
  input  wire logic        bit_rev,
  input  wire logic        byte_rev,
  input  wire logic        chk,
  input  wire logic [31:0] expect_val,
  output logic      [31:0] crc,
  output logic             fault
);
  function automatic logic [31:0] mirror(input logic [31:0] d, input logic br,
                                         input logic yr);
    logic [31:0] r;
    logic [31:0] q;
    r = yr ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    q = r;
    if (br) begin
      for (int i = 0; i < 32; i++) begin
        q[i] = r[(i & ~7) | (7 - (i & 7))];
      end
    end
    return q;
  endfunction

  // msb-first serial form unrolled over one word; one word per clock
  function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] d,
                                       input logic [31:0] p);
    logic [31:0] s;
    logic        fb;
    s = c;
    for (int i = 31; i >= 0; i--) begin
      fb = s[31] ^ d[i];
      s = {s[30:0], 1'b0} ^ (fb ? p : 32'h0);
    end
    return s;
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc <= `DMX_CRC_SEED;
    end else if (clr) begin
      crc <= `DMX_CRC_SEED;
    end else if (feed) begin
      crc <= step(crc, mirror(din, bit_rev, byte_rev), poly); // (R16) (R20)
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault <= 1'b0;
    end else begin
      fault <= chk && (crc != expect_val); // (R19)
    end
  end

  property p_fault;
    @(posedge ref_clk) disable iff (!reset_n)
    (chk && crc != expect_val) |=> fault;
  endproperty
  a_fault: assert property (p_fault) else $error("signature mismatch not flagged"); // (R19)
endmodule
`default_nettype wire

//--- verilog/dmx_top.sv
// dmx_top: one memory-to-memory channel pair with crc path and descriptors.
// assumes a single-clock memory port that answers each request with mem_ack.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"
// Operation
// (R1) a start needs only values written into the control registers
// (R2) register mode reloads the programmed setup when a sequence ends
// (R3) descriptor mode reads its parameter set from memory first
// (R4) descriptor sequences chain to the next without processor help
// (R5) single linear mode halts once the buffer is done
// (R6) address step may be negative, positive or zero
// (R7) circular mode wraps and interrupts at each full buffer
// (R8) circular variant also interrupts at the halfway point
// (R9) ping-pong ring of descriptors holding next pointer and address
// (R10) 1d list descriptors hold next, address, length and config
// (R11) 2d array descriptors give only a new base address
// (R12) 2d list descriptors carry every channel parameter; the code takes the destination address from the register instead
// (R13) copies use a source read channel and a destination write channel
// (R14) crc-capable pair moves 32-bit words on the system clock
// (R15) widest pair moves 64-bit words on the system clock
// (R16) crc32 is accumulated over each 32-bit word
// (R17) scan mode feeds source words to the crc only
// (R18) transfer mode also forwards each word to the destination
// (R19) hardware compares signature with expected value and flags faults
// (R20) optional bit and byte mirroring, programmable polynomial
// (R21) fill mode writes a constant into a 1d or 2d block
// (R22) separate interrupt outputs for faults and for errors
// (R23) sequence end raises a trigger that can start another channel
// (R24) descriptor entries are read in listed order before transfer
module dmx_top
  import dmx_pkg::*;
#(
  parameter int MEM_W = 64
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  output logic                  mem_req,
  output logic                  mem_we,
  output logic      [31:0]      mem_addr,
  output logic      [MEM_W-1:0] mem_wdata,
  input  wire logic [MEM_W-1:0] mem_rdata,
  input  wire logic             mem_ack,
  input  wire logic             trig_in,
  output logic                  trig_out,
  output logic                  done_irq,
  output logic                  half_irq,
  output logic                  crc_fault_irq,
  output logic                  crc_err_irq
);
  logic [31:0] ctrl, src_addr, dst_addr, count, stride;
  logic [31:0] dptr, ycnt, poly, expect_val, fill;
  logic [31:0] cur_src, cur_dst, cur_cnt, cur_stride, w_len;
  logic [31:0] nxt_ptr, ptr, yleft, ystride;
  logic [MEM_W-1:0] data_buf;
  logic [31:0] crc_data, crc_val;
  logic [2:0]  didx;
  logic        cfg_stop, wide, half_en, err_flag;
  logic        crc_clr, crc_feed, crc_chk;
  dmx_state_t  state;
  dmx_mode_t   mode;
  dmx_op_t     op;

  function automatic logic [2:0] desc_words(input dmx_mode_t m);
    case (m)
      M_RING:  desc_words = 3'h2; // (R9)
      M_LIST1: desc_words = 3'h4; // (R10)
      M_LIST2: desc_words = 3'h6; // (R12)
      default: desc_words = 3'h1; // (R11)
    endcase
  endfunction

  function automatic dmx_field_t desc_field(input dmx_mode_t m, input logic [2:0] i);
    if (m == M_ARRAY2) begin
      return FD_ADDR; // (R11)
    end
    return dmx_field_t'(i); // (R24)
  endfunction

  function automatic dmx_state_t first_state(input dmx_op_t o);
    return (o == OP_FILL) ? S_WR : S_RD; // (R21)
  endfunction

  // a start arrives by a control write or, when enabled, a trigger
  logic [31:0] go_ctrl;
  logic        start_cmd;
  dmx_mode_t   go_mode;
  assign go_ctrl   = (reg_wr && reg_addr == `DMX_CTRL) ? reg_wdata : ctrl;
  assign go_mode   = dmx_mode_t'(go_ctrl[`DMX_F_MODE_HI:`DMX_F_MODE_LO]);
  assign start_cmd = (reg_wr && reg_addr == `DMX_CTRL && reg_wdata[`DMX_F_START])
                   || (trig_in && ctrl[`DMX_F_TRIGEN]); // (R1) (R23)

  logic [31:0] ebytes;
  assign ebytes = wide ? `DMX_WIDE_STEP : `DMX_NARROW_STEP;

  // register file; start is a command and is not kept
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= `DMX_RST_WORD;
      src_addr   <= `DMX_RST_WORD;
      dst_addr   <= `DMX_RST_WORD;
      count      <= `DMX_RST_WORD;
      stride     <= `DMX_RST_WORD;
      dptr       <= `DMX_RST_WORD;
      ycnt       <= `DMX_RST_WORD;
      poly       <= `DMX_RST_POLY;
      expect_val <= `DMX_RST_WORD;
      fill       <= `DMX_RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        `DMX_CTRL:   ctrl <= reg_wdata & ~(32'h1 << `DMX_F_START);
        `DMX_SRC:    src_addr <= reg_wdata;
        `DMX_DST:    dst_addr <= reg_wdata;
        `DMX_CNT:    count <= reg_wdata;
        `DMX_STRIDE: stride <= reg_wdata; // (R6)
        `DMX_DPTR:   dptr <= reg_wdata;
        `DMX_YCNT:   ycnt <= reg_wdata;
        `DMX_POLY:   poly <= reg_wdata; // (R20)
        `DMX_EXPECT: expect_val <= reg_wdata;
        `DMX_FILL:   fill <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data stands one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `DMX_RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        `DMX_CTRL:   reg_rdata <= ctrl;
        `DMX_SRC:    reg_rdata <= cur_src;
        `DMX_DST:    reg_rdata <= cur_dst;
        `DMX_CNT:    reg_rdata <= cur_cnt;
        `DMX_STRIDE: reg_rdata <= stride;
        `DMX_DPTR:   reg_rdata <= ptr;
        `DMX_YCNT:   reg_rdata <= ycnt;
        `DMX_POLY:   reg_rdata <= poly;
        `DMX_EXPECT: reg_rdata <= expect_val;
        `DMX_FILL:   reg_rdata <= fill;
        `DMX_STAT:   reg_rdata <= {30'h0, err_flag, state != S_IDLE};
        `DMX_CRC:    reg_rdata <= crc_val;
        default:     reg_rdata <= `DMX_RST_WORD;
      endcase
    end else begin
      reg_rdata <= `DMX_RST_WORD;
    end
  end

  // sticky error; a new event in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_flag <= 1'b0;
    end else if (crc_err_irq || crc_fault_irq) begin
      err_flag <= 1'b1;
    end else if (reg_wr && reg_addr == `DMX_STAT && reg_wdata[`DMX_F_ERR]) begin
      err_flag <= 1'b0;
    end
  end

  // channel engine: source read then destination write over one port
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= S_IDLE;
      mode       <= M_STOP;
      op         <= OP_COPY;
      wide       <= 1'b0;
      half_en    <= 1'b0;
      cur_src    <= `DMX_RST_WORD;
      cur_dst    <= `DMX_RST_WORD;
      cur_cnt    <= `DMX_RST_WORD;
      cur_stride <= `DMX_RST_WORD;
      w_len      <= `DMX_RST_WORD;
      nxt_ptr    <= `DMX_RST_WORD;
      ptr        <= `DMX_RST_WORD;
      yleft      <= `DMX_RST_WORD;
      ystride    <= `DMX_RST_WORD;
      didx       <= 3'h0;
      cfg_stop   <= 1'b0;
      data_buf   <= '0;
      crc_data   <= `DMX_RST_WORD;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= `DMX_RST_WORD;
      mem_wdata  <= '0;
      done_irq   <= 1'b0;
      half_irq   <= 1'b0;
      trig_out   <= 1'b0;
      crc_clr    <= 1'b0;
      crc_feed   <= 1'b0;
      crc_chk    <= 1'b0;
      crc_err_irq <= 1'b0;
    end else begin
      done_irq    <= 1'b0;
      half_irq    <= 1'b0;
      trig_out    <= 1'b0;
      crc_clr     <= 1'b0;
      crc_feed    <= 1'b0;
      crc_chk     <= 1'b0;
      crc_err_irq <= 1'b0;
      // one outstanding request; issued the cycle after entering a state
      if (!mem_req && (state == S_FETCH || state == S_RD || state == S_WR)) begin
        mem_req <= 1'b1;
        mem_we  <= (state == S_WR); // (R13)
        case (state)
          S_FETCH: mem_addr <= ptr + (32'(didx) << 2); // (R24)
          S_RD:    mem_addr <= cur_src;
          default: mem_addr <= cur_dst;
        endcase
        mem_wdata <= (op == OP_FILL) ? MEM_W'(fill) : data_buf; // (R21)
      end else if (mem_ack) begin
        mem_req <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (start_cmd) begin
            mode       <= go_mode;
            op         <= dmx_op_t'(go_ctrl[`DMX_F_OP_HI:`DMX_F_OP_LO]);
            wide       <= go_ctrl[`DMX_F_WIDE]; // (R15)
            half_en    <= go_ctrl[`DMX_F_HALF];
            crc_clr    <= 1'b1;
            cur_src    <= src_addr;
            cur_dst    <= dst_addr;
            cur_cnt    <= count;
            w_len      <= count;
            cur_stride <= stride;
            yleft      <= ycnt;
            cfg_stop   <= 1'b0;
            ptr        <= dptr;
            didx       <= 3'h0;
            if (go_mode == M_STOP || go_mode == M_CIRC) begin
              state <= first_state(dmx_op_t'(go_ctrl[`DMX_F_OP_HI:`DMX_F_OP_LO])); // (R1)
            end else if (go_mode > M_LIST2) begin
              crc_err_irq <= 1'b1; // (R22)
            end else begin
              state <= S_FETCH; // (R3)
            end
          end
        end
        S_FETCH: begin
          if (mem_req && mem_ack) begin
            case (desc_field(mode, didx))
              FD_NEXT: nxt_ptr <= mem_rdata[31:0]; // (R9)
              FD_ADDR: cur_src <= mem_rdata[31:0]; // (R11)
              FD_LEN:  w_len <= mem_rdata[31:0]; // (R10)
              FD_CFG: begin
                cfg_stop   <= mem_rdata[`DMX_F_CFG_STOP];
                cur_stride <= {{16{mem_rdata[31]}}, mem_rdata[31:`DMX_F_CFG_STR]};
              end
              FD_YCNT: yleft <= mem_rdata[31:0]; // (R12)
              FD_YSTR: ystride <= mem_rdata[31:0];
              default: ;
            endcase
            if (didx == desc_words(mode) - 3'h1) begin
              cur_cnt <= w_len;
              state   <= first_state(op);
            end else begin
              didx <= didx + 3'h1;
            end
          end
        end
        S_RD: begin
          if (mem_req && mem_ack) begin
            data_buf <= wide ? mem_rdata : MEM_W'(mem_rdata[31:0]); // (R14)
            crc_data <= mem_rdata[31:0];
            crc_feed <= (op == OP_SCAN || op == OP_XFER); // (R17)
            if (op == OP_VERIFY && mem_rdata[31:0] != fill) begin
              crc_err_irq <= 1'b1;
            end
            state <= (op == OP_COPY || op == OP_XFER) ? S_WR : S_NEXT; // (R18)
          end
        end
        S_WR: begin
          if (mem_req && mem_ack) begin
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          cur_src <= cur_src + cur_stride; // (R6)
          cur_dst <= cur_dst + ebytes;
          if (cur_cnt > 32'h1) begin
            cur_cnt <= cur_cnt - 32'h1;
            state   <= first_state(op);
            if (half_en && mode == M_CIRC && cur_cnt - 32'h1 == (w_len >> 1)) begin
              half_irq <= 1'b1; // (R8)
            end
          end else if (mode == M_LIST2 && yleft > 32'h1) begin
            yleft   <= yleft - 32'h1;
            cur_cnt <= w_len;
            cur_src <= cur_src + cur_stride + ystride; // (R12)
            state   <= first_state(op);
          end else begin
            done_irq <= 1'b1;
            trig_out <= 1'b1; // (R23)
            crc_chk  <= (op == OP_SCAN || op == OP_XFER); // (R19)
            didx     <= 3'h0;
            case (mode)
              M_STOP, M_CIRC: begin
                cur_src    <= src_addr; // (R2)
                cur_dst    <= dst_addr;
                cur_cnt    <= count;
                w_len      <= count;
                cur_stride <= stride;
                state      <= (mode == M_CIRC) ? first_state(op) : S_IDLE; // (R5) (R7)
              end
              M_ARRAY2: begin
                yleft <= yleft - 32'h1;
                ptr   <= ptr + `DMX_DESC_STEP;
                state <= (yleft > 32'h1) ? S_FETCH : S_IDLE; // (R11)
              end
              M_RING: begin
                ptr   <= nxt_ptr;
                state <= S_FETCH; // (R4)
              end
              M_LIST1, M_LIST2: begin
                ptr   <= nxt_ptr;
                state <= cfg_stop ? S_IDLE : S_FETCH; // (R4)
              end
              default: state <= S_IDLE;
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // signature path; its fault flop drives the fault output directly
  dmx_crc u_crc (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clr        (crc_clr),
    .feed       (crc_feed),
    .din        (crc_data),
    .poly       (poly),
    .bit_rev    (ctrl[`DMX_F_BITREV]),
    .byte_rev   (ctrl[`DMX_F_BYTEREV]),
    .chk        (crc_chk),
    .expect_val (expect_val),
    .crc        (crc_val),
    .fault      (crc_fault_irq)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_reg_start;
    (state == S_IDLE && start_cmd && go_mode == M_STOP)
      |=> (state != S_IDLE && cur_cnt == $past(count));
  endproperty
  a_reg_start: assert property (p_reg_start) else $error("register start failed"); // (R1)
  property p_reload;
    (done_irq && mode == M_STOP) |-> (cur_src == src_addr && cur_cnt == count);
  endproperty
  a_reload: assert property (p_reload) else $error("setup not reloaded"); // (R2)
  property p_fetch;
    (state == S_IDLE && start_cmd && go_mode == M_LIST1)
      |-> ##2 (mem_req && !mem_we && mem_addr == $past(dptr, 2));
  endproperty
  a_fetch: assert property (p_fetch) else $error("descriptor not fetched"); // (R3)
  property p_chain;
    (done_irq && mode == M_RING) |-> (state == S_FETCH && didx == 3'h0) ##1 mem_req;
  endproperty
  a_chain: assert property (p_chain) else $error("ring did not chain"); // (R4)
  property p_stop;
    (done_irq && mode == M_STOP) |-> state == S_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("linear mode did not halt"); // (R5)
  property p_stride;
    (state == S_NEXT && cur_cnt > 32'h1) |=> cur_src == $past(cur_src) + $past(cur_stride);
  endproperty
  a_stride: assert property (p_stride) else $error("address step wrong"); // (R6)
  property p_circ;
    (done_irq && mode == M_CIRC) |-> (state != S_IDLE && cur_src == src_addr);
  endproperty
  a_circ: assert property (p_circ) else $error("circular buffer did not wrap"); // (R7)
  property p_trig;
    done_irq |-> trig_out;
  endproperty
  a_trig: assert property (p_trig) else $error("no trigger at sequence end"); // (R23)
  property p_scan;
    (mem_req && op == OP_SCAN) |-> !mem_we;
  endproperty
  a_scan: assert property (p_scan) else $error("scan wrote memory"); // (R17)
  property p_fill;
    (mem_req && mem_we && op == OP_FILL) |-> mem_wdata[31:0] == fill;
  endproperty
  a_fill: assert property (p_fill) else $error("fill value wrong"); // (R21)
endmodule
`default_nettype wire

//--- tb/dmx_mem.sv
// dmx_mem: word memory on the far side of the channel pair memory port.
// assumes one request at a time inside a 1 KB window of byte addresses.
`timescale 1ns/1ps
`default_nettype none
module dmx_mem (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic      [63:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] words [0:255];
  logic [1:0]  wait_cnt;
  // slow mode stalls each answer so the held request is exercised
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      mem_rdata <= 64'h0;
    end else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
      mem_ack  <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem_we)
        words[mem_addr[9:2]] <= mem_wdata[31:0];
      else
        mem_rdata <= {words[mem_addr[9:2] + 8'h1], words[mem_addr[9:2]]};
    end else begin
      mem_ack   <= 1'b0;
      wait_cnt  <= mem_req ? wait_cnt + 2'h1 : 2'h0;
      // stale data is inverted each cycle so it never passes for a fresh answer
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_dmx_top.sv
// test_dmx_top: register driven checks of one channel pair against a word memory.
// assumes dmx_mem on the memory port and narrow 32-bit elements throughout.
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_dmx_top
  import dmx_pkg::*;
;
  logic        ref_clk, reset_n, reg_wr, reg_rd, mem_req, mem_we, mem_ack, slow;
  logic        trig_in, trig_out, done_irq, half_irq, crc_fault_irq, crc_err_irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, d, c, p;
  logic [63:0] mem_wdata, mem_rdata;
  logic [31:0] dl [0:7] = '{32'h50, 32'h100, 32'h1, 32'h0, 32'h0, 32'h108, 32'h1, 32'h1};
  int          checked, bad_count, done_cnt, fault_cnt, err_cnt, trig_cnt, half_cnt, n, h;
  dmx_top #(.MEM_W(64)) dmx_top_i (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .trig_in, .trig_out, .done_irq, .half_irq, .crc_fault_irq, .crc_err_irq);
  dmx_mem dmx_mem_i (.ref_clk, .reset_n, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    done_cnt  += int'(done_irq === 1'b1);
    fault_cnt += int'(crc_fault_irq === 1'b1);
    err_cnt   += int'(crc_err_irq === 1'b1);
    trig_cnt  += int'(trig_out === 1'b1);
    half_cnt  += int'(half_irq === 1'b1);
  end
  function automatic logic [31:0] pat(input int i);
    return {8'ha5, 8'(i), 8'h3c, 8'(~i)};
  endfunction
  function automatic logic [31:0] crc_of(input logic [31:0] s, w, q);
    for (int i = 31; i >= 0; i--) s = {s[30:0], 1'b0} ^ ((s[31] ^ w[i]) ? q : 32'h0);
    return s;
  endfunction
  function automatic logic [31:0] cw(input dmx_mode_t m, input dmx_op_t o, input logic [31:0] x);
    return x | (32'(o) << `DMX_F_OP_LO) | (32'(m) << `DMX_F_MODE_LO) | 32'h1;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // a control word without start is launched by the trigger input instead
  task automatic go(input logic [31:0] ctrl);
    logic [31:0] s;
    wr(`DMX_CTRL, ctrl);
    if (!ctrl[`DMX_F_START]) begin
      trig_in <= 1'b1;
      @(posedge ref_clk);
      trig_in <= 1'b0;
    end
    s = 32'h1;
    for (int i = 0; i < 400 && s[`DMX_F_BUSY]; i++) rd(`DMX_STAT, s);
    if (s[`DMX_F_BUSY] !== 1'b0) begin
      $display("MISMATCH busy expected 0 seen %h", s);
      bad_count++;
      complete_run();
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {ref_clk, reset_n, reg_wr, reg_rd, slow, trig_in} = '0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    for (int i = 0; i < 256; i++) dmx_mem_i.words[i] = pat(i);
    for (int i = 0; i < 8; i++) dmx_mem_i.words[16 + i] = dl[i];
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`DMX_POLY, d);
    `CHK("poly", `DMX_RST_POLY, d)
    rd(8'h30, d);
    `CHK("unmapped", 32'h0, d)
    // stride 4, 0 and -4; the last pass also feeds the crc
    for (int k = 0; k < 3; k++) begin
      slow <= k[0];
      wr(`DMX_SRC, 32'h120);
      wr(`DMX_DST, 32'h200 + 32'(k) * 32'h20);
      wr(`DMX_CNT, 32'h3);
      wr(`DMX_STRIDE, 32'h4 - 32'(k) * 32'h4);
      n = done_cnt;
      go(cw(M_STOP, k == 2 ? OP_XFER : OP_COPY, 32'h0));
      `CHK("done", n + 1, done_cnt)
      c = `DMX_CRC_SEED;
      for (int i = 0; i < 3; i++) begin
        `CHK("copy", pat(72 + i * (1 - k)), dmx_mem_i.words[128 + k * 8 + i])
        c = crc_of(c, pat(72 + i * (1 - k)), `DMX_RST_POLY);
      end
      rd(`DMX_SRC, d);
      `CHK("reload", 32'h120, d)
      rd(`DMX_CRC, d);
      if (k == 2) `CHK("xfer crc", c, d)
    end
    wr(`DMX_DST, 32'h2c0);
    n = done_cnt;
    go(cw(M_STOP, OP_COPY, 32'h800) & ~32'h1);
    `CHK("trig start", n + 1, done_cnt)
    `CHK("trig copy", pat(70), dmx_mem_i.words[178])
    wr(`DMX_STRIDE, 32'h4);
    wr(`DMX_FILL, 32'h6b1e0f00);
    wr(`DMX_DST, 32'h300);
    wr(`DMX_CNT, 32'h2);
    go(cw(M_STOP, OP_FILL, 32'h0));
    `CHK("fill", 32'h6b1e0f00, dmx_mem_i.words[193])
    wr(`DMX_SRC, 32'h300);
    n = err_cnt;
    go(cw(M_STOP, OP_VERIFY, 32'h0));
    `CHK("verify ok", n, err_cnt)
    wr(`DMX_FILL, 32'h6b1e0f01);
    go(cw(M_STOP, OP_VERIFY, 32'h0));
    // both compared words differ from the fill value, so two error pulses
    `CHK("verify bad", n + 2, err_cnt)
    wr(`DMX_SRC, 32'h100);
    // default polynomial, byte mirrored input, then a programmed polynomial
    for (int k = 0; k < 3; k++) begin
      p = (k == 2) ? 32'h1edc6f41 : `DMX_RST_POLY;
      wr(`DMX_POLY, p);
      c = `DMX_CRC_SEED;
      for (int i = 0; i < 2; i++) begin
        d = pat(64 + i);
        if (k == 1) d = {d[7:0], d[15:8], d[23:16], d[31:24]};
        c = crc_of(c, d, p);
      end
      wr(`DMX_EXPECT, c ^ 32'h1);
      n = fault_cnt;
      go(cw(M_STOP, OP_SCAN, k == 1 ? 32'h100 : 32'h0));
      `CHK("fault", n + 1, fault_cnt)
      rd(`DMX_CRC, d);
      `CHK("scan crc", c, d)
      wr(`DMX_EXPECT, c);
      go(cw(M_STOP, OP_SCAN, k == 1 ? 32'h100 : 32'h0));
      `CHK("no fault", n + 1, fault_cnt)
    end
    wr(`DMX_DPTR, 32'h40);
    wr(`DMX_DST, 32'h380);
    go(cw(M_LIST1, OP_COPY, 32'h0));
    `CHK("desc one", pat(64), dmx_mem_i.words[224])
    `CHK("desc two", pat(66), dmx_mem_i.words[225])
    rd(`DMX_STAT, d);
    `CHK("sticky err", 32'h2, d)
    // two one-word descriptors at 0x50 give source bases 0x0 and 0x108
    wr(`DMX_DPTR, 32'h50);
    wr(`DMX_YCNT, 32'h2);
    wr(`DMX_DST, 32'h3a0);
    go(cw(M_ARRAY2, OP_COPY, 32'h0));
    `CHK("array", pat(66), dmx_mem_i.words[234])
    // circular never stops by itself; a reset in mid-run ends it
    wr(`DMX_DST, 32'h3c0);
    n = done_cnt;
    h = half_cnt;
    wr(`DMX_CTRL, cw(M_CIRC, OP_COPY, 32'h400));
    for (int i = 0; i < 300 && done_cnt < n + 2; i++) @(posedge ref_clk);
    `CHK("circ wrap", n + 2, done_cnt)
    `CHK("half", h + 2, half_cnt)
    `CHK("circ copy", pat(65), dmx_mem_i.words[241])
    if (done_cnt < n + 2) complete_run();
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`DMX_STAT, d);
    `CHK("reset idle", 32'h0, d)
    `CHK("done total", 19, done_cnt)
    `CHK("trig total", 19, trig_cnt)
    complete_run();
  end
endmodule
`default_nettype wire
